// *** verilog/ferc_pkg.sv ***
// Package: constants and carrier types for the fault event routing bank
package ferc_pkg;
    // Command codes seen by the bank (chosen values)
    localparam logic [7:0] CMD_RD_STATUS_TWO = 8'h0A;
    localparam logic [7:0] CMD_RD_FAULT_RESET = 8'h0B;
    localparam logic [7:0] CMD_WR_FAULT_RESET = 8'h1B;
    localparam logic [7:0] CMD_RD_THERMAL_IRQ = 8'h0C;
    localparam logic [7:0] CMD_WR_THERMAL_IRQ = 8'h1C;
    localparam logic [7:0] CMD_WAKE_CLEAR = 8'h2D;
    localparam logic [7:0] WAKE_CLEAR_DATA = 8'h8E;
    // Reset values
    localparam logic [7:0] FAULT_RESET_RST = 8'h0B;
    localparam logic [7:0] THERMAL_IRQ_RST = 8'h00;
    // Writable masks; reserved bits of thermal routing read zero
    localparam logic [7:0] FAULT_RESET_WMASK = 8'hFF;
    localparam logic [7:0] THERMAL_IRQ_WMASK = 8'h0B;
    // Field positions
    localparam int WAKE_LVL_BIT = 0;
    localparam int WAKE_EDGE_BIT = 1;
    localparam int OV_BOOST_BIT = 7;
    localparam int OV_BUCK2_BIT = 5;
    localparam int OV_BUCK1_BIT = 4;
    localparam int UV_BOOST_BIT = 3;
    localparam int UV_BUCK2_BIT = 1;
    localparam int UV_BUCK1_BIT = 0;
    localparam int OT_BOOST_BIT = 3;
    localparam int OT_BUCK2_BIT = 1;
    localparam int OT_BUCK1_BIT = 0;
    localparam int NUM_REG = 3;
    // Regulator index order: boost, second buck, first buck
    typedef struct packed {
        logic boost;
        logic buck2;
        logic buck1;
    } ferc_reg3_t;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [7:0] data;
    } ferc_cmd_t;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_DIAG,
        ST_ACTIVE,
        ST_SAFE
    } ferc_state_t;
endpackage

// *** verilog/ferc_cfg_store.sv ***
// Small register store: writable config bytes with registered readout
`timescale 1ns/1ps
`default_nettype none
module ferc_cfg_store
    import ferc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_sel_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [1:0] rd_sel_i,
    input wire logic [7:0] stat_i,
    output logic [7:0] fault_reset_o,
    output logic [7:0] thermal_irq_o,
    output logic [7:0] rd_data_o
);
    logic [7:0] fault_reset_r;
    logic [7:0] thermal_irq_r;
    logic [7:0] rd_data_r;
    wire logic [7:0] rd_mux;
    assign rd_mux = (rd_sel_i == 2'd1) ? fault_reset_r :
                    (rd_sel_i == 2'd2) ? thermal_irq_r : stat_i;
    // Power-on values come from the async reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_reset_r <= FAULT_RESET_RST;
            thermal_irq_r <= THERMAL_IRQ_RST;
        end else if (wr_en_i && wr_sel_i == 2'd1) begin
            fault_reset_r <= wr_data_i & FAULT_RESET_WMASK;
        end else if (wr_en_i && wr_sel_i == 2'd2) begin
            thermal_irq_r <= wr_data_i & THERMAL_IRQ_WMASK;
        end
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_r <= 8'h00;
        end else if (rd_en_i) begin
            rd_data_r <= rd_mux;
        end
    end
    assign fault_reset_o = fault_reset_r;
    assign thermal_irq_o = thermal_irq_r;
    assign rd_data_o = rd_data_r;
endmodule
`default_nettype wire

// *** verilog/ferc_bank.sv ***
// Fault event routing configuration and wake status bank
`timescale 1ns/1ps
`default_nettype none
module ferc_bank
    import ferc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire ferc_cmd_t cmd_i,
    input wire ferc_state_t state_i,
    input wire logic cfg_lock_i,
    input wire logic wake_level_i,
    input wire ferc_reg3_t ov_fault_i,
    input wire ferc_reg3_t uv_fault_i,
    input wire ferc_reg3_t ot_warn_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] status_two_o,
    output logic [15:0] config_checksum_data_o,
    output logic global_reset_o,
    output logic enter_safe_o,
    output logic enable_drive_clear_o,
    output logic enable_drive_irq_pin_o,
    output logic enable_drive_irq_pin_oe_o,
    output ferc_reg3_t thermal_warn_status_o
);
    ////////////////////////////////////////////////////////////////////////
    logic wake_level_r;
    logic wake_edge_r;
    logic wake_edge_nxt;
    logic irq_r;
    ferc_reg3_t warn_r;
    ferc_state_t state_q;
    logic [7:0] fault_reset;
    logic [7:0] thermal_irq;
    wire logic is_wr_fr;
    wire logic is_wr_ti;
    wire logic wr_ok;
    wire logic wr_en;
    wire logic [1:0] wr_sel;
    wire logic rd_en;
    wire logic [1:0] rd_sel;
    wire logic wake_clear;
    wire logic wake_rise;
    wire logic off_entry;
    wire ferc_reg3_t ov_en;
    wire ferc_reg3_t uv_en;
    wire ferc_reg3_t ot_en;
    wire logic irq_event;

    function automatic logic is_cmd(input ferc_cmd_t c, input logic [7:0] k);
        return c.valid && (c.code == k);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    assign is_wr_fr = is_cmd(cmd_i, CMD_WR_FAULT_RESET);
    assign is_wr_ti = is_cmd(cmd_i, CMD_WR_THERMAL_IRQ);
    assign wr_ok = (state_i == ST_DIAG) && !cfg_lock_i;
    assign wr_en = (is_wr_fr || is_wr_ti) && wr_ok;
    assign wr_sel = is_wr_fr ? 2'd1 : 2'd2;
    assign rd_en = is_cmd(cmd_i, CMD_RD_STATUS_TWO)
                || is_cmd(cmd_i, CMD_RD_FAULT_RESET)
                || is_cmd(cmd_i, CMD_RD_THERMAL_IRQ);
    assign rd_sel = is_cmd(cmd_i, CMD_RD_FAULT_RESET) ? 2'd1 :
                    is_cmd(cmd_i, CMD_RD_THERMAL_IRQ) ? 2'd2 : 2'd0;
    assign wake_clear = is_cmd(cmd_i, CMD_WAKE_CLEAR)
                     && (cmd_i.data == WAKE_CLEAR_DATA);

    ferc_cfg_store u_store (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(wr_en),
        .wr_sel_i(wr_sel),
        .wr_data_i(cmd_i.data),
        .rd_en_i(rd_en),
        .rd_sel_i(rd_sel),
        .stat_i(status_two_o),
        .fault_reset_o(fault_reset),
        .thermal_irq_o(thermal_irq),
        .rd_data_o(rd_data_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wake status
    assign wake_rise = wake_level_i && !wake_level_r;
    assign off_entry = (state_i == ST_OFF) && (state_q != ST_OFF);
    // Edge wins over a same-cycle clear so no event is lost
    assign wake_edge_nxt = wake_rise ? 1'b1 :
        ((wake_clear || off_entry) ? 1'b0 : wake_edge_r);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_level_r <= 1'b0;
            wake_edge_r <= 1'b0;
            state_q <= ST_OFF;
        end else begin
            wake_level_r <= wake_level_i;
            wake_edge_r <= wake_edge_nxt;
            state_q <= state_i;
        end
    end

    assign status_two_o = {6'b00_0000, wake_edge_r, wake_level_r};

    ////////////////////////////////////////////////////////////////////////
    // Fault routing
    assign ov_en = {fault_reset[OV_BOOST_BIT], fault_reset[OV_BUCK2_BIT],
                    fault_reset[OV_BUCK1_BIT]};
    assign uv_en = {fault_reset[UV_BOOST_BIT], fault_reset[UV_BUCK2_BIT],
                    fault_reset[UV_BUCK1_BIT]};
    assign ot_en = {thermal_irq[OT_BOOST_BIT], thermal_irq[OT_BUCK2_BIT],
                    thermal_irq[OT_BUCK1_BIT]};
    assign global_reset_o = |(ov_fault_i & ov_en)
                         || |(uv_fault_i & uv_en);
    assign irq_event = |(ot_warn_i & ot_en);

    // Irq latches until the next reset; safe state handling lies outside
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            warn_r <= '0;
            irq_r <= 1'b0;
        end else begin
            warn_r <= warn_r | ot_warn_i;
            irq_r <= irq_r | irq_event;
        end
    end

    assign thermal_warn_status_o = warn_r;
    assign enable_drive_irq_pin_o = 1'b0;
    assign enable_drive_irq_pin_oe_o = irq_r;
    assign enable_drive_clear_o = irq_event;
    assign enter_safe_o = irq_event;
    assign config_checksum_data_o = {fault_reset, thermal_irq};

    ////////////////////////////////////////////////////////////////////////
    refused_write_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (is_wr_fr && !wr_ok) |=> $stable(fault_reset))
        else $error("refused write changed fault routing");
    accepted_write_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (is_wr_fr && wr_ok) |=> fault_reset == $past(cmd_i.data))
        else $error("accepted write not stored");
    wake_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        wake_rise |=> status_two_o[WAKE_EDGE_BIT])
        else $error("wake edge not latched");
    wake_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (wake_clear && !wake_rise) |=> !status_two_o[WAKE_EDGE_BIT])
        else $error("wake clear ignored");
    off_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (off_entry && !wake_rise) |=> !status_two_o[WAKE_EDGE_BIT])
        else $error("off entry did not clear wake");
    wake_level_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        1'b1 |=> status_two_o[WAKE_LVL_BIT] == $past(wake_level_i))
        else $error("wake level mismatch");
    ov_route_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (ov_fault_i.boost && fault_reset[OV_BOOST_BIT]) |-> global_reset_o)
        else $error("boost overvoltage not routed");
    warn_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        ot_warn_i.buck1 |=> thermal_warn_status_o.buck1)
        else $error("warning status not set");
    irq_pin_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        irq_event |=> enable_drive_irq_pin_oe_o[*3])
        else $error("irq pin not pulled low");
    // Checked against raw register bits, not the shared event wire
    safe_entry_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (ot_warn_i.boost && thermal_irq[OT_BOOST_BIT])
            |-> (enter_safe_o && enable_drive_clear_o))
        else $error("safe entry missing");
    safe_quiet_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (ot_warn_i == '0) |-> !(enter_safe_o || enable_drive_clear_o))
        else $error("safe entry without warning");
    uv_route_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (uv_fault_i.buck2 && fault_reset[UV_BUCK2_BIT]) |-> global_reset_o)
        else $error("buck2 undervoltage not routed");
    reset_quiet_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (ov_fault_i == '0 && uv_fault_i == '0) |-> !global_reset_o)
        else $error("global reset without fault");
    refused_thermal_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (is_wr_ti && !wr_ok) |=> $stable(thermal_irq))
        else $error("refused write changed thermal routing");
    thermal_write_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (is_wr_ti && wr_ok) |=>
            thermal_irq == ($past(cmd_i.data) & THERMAL_IRQ_WMASK))
        else $error("accepted thermal write not stored");
    wake_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        !(wake_rise || wake_clear || off_entry)
            |=> $stable(status_two_o[WAKE_EDGE_BIT]))
        else $error("wake latch changed without cause");
    read_answer_a: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        (rd_en && rd_sel == 2'd1) |=> rd_data_o == $past(fault_reset))
        else $error("fault routing read mismatch");
    cov_write: cover property (@(posedge clk_sys_i) wr_en);
    cov_refuse: cover property (@(posedge clk_sys_i)
        (is_wr_ti && !wr_ok));
    cov_wake: cover property (@(posedge clk_sys_i)
        wake_rise ##[1:20] wake_clear);
    cov_irq: cover property (@(posedge clk_sys_i) irq_event);
endmodule
`default_nettype wire

// *** test/ferc_mcu_model.sv ***
// Controller model: issues two-byte command frames (code and data) to the bank
`timescale 1ns/1ps
`default_nettype none
module ferc_mcu_model
    import ferc_pkg::*;
(
    input wire logic clk_sys_i,
    output ferc_cmd_t cmd_o
);
    initial cmd_o = '0;
    ////////////////////////////////////////////////////////////////////////
    // One frame per call; writes outside diag/unlocked are on purpose
    // only where a refusal is wanted
    task automatic send(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk_sys_i);
        #1 cmd_o = {1'b1, code, data};
        @(posedge clk_sys_i);
        // Released bus shows the inverse, never a stale frame
        #1 cmd_o = {1'b0, ~code, ~data};
    endtask
endmodule
`default_nettype wire

// *** test/test_ferc_bank.sv ***
// Self-checking bench for the fault event routing bank
`timescale 1ns/1ps
`default_nettype none
module test_ferc_bank
    import ferc_pkg::*;
    ;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    ferc_cmd_t cmd;
    ferc_state_t state_i = ST_OFF;
    logic cfg_lock_i = 1'b0;
    logic wake_level_i = 1'b0;
    ferc_reg3_t ov_fault_i = '0;
    ferc_reg3_t uv_fault_i = '0;
    ferc_reg3_t ot_warn_i = '0;
    logic [7:0] rd_data_o;
    logic [7:0] status_two_o;
    logic [15:0] cks;
    logic glob_rst, safe, drv_clr, irq_pin, irq_oe;
    ferc_reg3_t warn;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    ferc_mcu_model u_ferc_mcu_model(.clk_sys_i(clk_sys_i), .cmd_o(cmd));
    ferc_bank u_ferc_bank(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .cmd_i(cmd), .state_i(state_i), .cfg_lock_i(cfg_lock_i),
        .wake_level_i(wake_level_i), .ov_fault_i(ov_fault_i),
        .uv_fault_i(uv_fault_i), .ot_warn_i(ot_warn_i),
        .rd_data_o(rd_data_o), .status_two_o(status_two_o),
        .config_checksum_data_o(cks), .global_reset_o(glob_rst),
        .enter_safe_o(safe), .enable_drive_clear_o(drv_clr),
        .enable_drive_irq_pin_o(irq_pin),
        .enable_drive_irq_pin_oe_o(irq_oe),
        .thermal_warn_status_o(warn));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        u_ferc_mcu_model.send(code, 8'h00);
        step();
        chk(rd_data_o, exp);
    endtask
    // One regulator at a time, so a swapped bit shows
    task automatic faults(input logic ov_on, input logic exp);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys_i);
            #1 ov_fault_i = ov_on ? ferc_reg3_t'(3'b100 >> i) : '0;
            uv_fault_i = ov_on ? '0 : ferc_reg3_t'(3'b100 >> i);
            #1 chk(glob_rst, exp);
        end
        @(posedge clk_sys_i);
        #1 ov_fault_i = '0;
        uv_fault_i = '0;
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        rd(CMD_RD_FAULT_RESET, 8'h0B);
        rd(CMD_RD_THERMAL_IRQ, 8'h00);
        rd(CMD_RD_STATUS_TWO, 8'h00);
        chk(cks, 16'h0B00);
        faults(1'b1, 1'b0);
        faults(1'b0, 1'b1);
        // Refused writes: wrong state, then locked
        state_i = ST_ACTIVE;
        u_ferc_mcu_model.send(CMD_WR_FAULT_RESET, 8'hF0);
        rd(CMD_RD_FAULT_RESET, 8'h0B);
        state_i = ST_DIAG;
        cfg_lock_i = 1'b1;
        u_ferc_mcu_model.send(CMD_WR_THERMAL_IRQ, 8'h0B);
        rd(CMD_RD_THERMAL_IRQ, 8'h00);
        cfg_lock_i = 1'b0;
        u_ferc_mcu_model.send(CMD_WR_FAULT_RESET, 8'hB0);
        rd(CMD_RD_FAULT_RESET, 8'hB0);
        u_ferc_mcu_model.send(CMD_WR_THERMAL_IRQ, 8'hFE);
        rd(CMD_RD_THERMAL_IRQ, 8'h0A);
        chk(cks, 16'hB00A);
        faults(1'b1, 1'b1);
        faults(1'b0, 1'b0);
        // Warning with its enable clear: status only; boost warning with enable set: safe entry and irq
        @(posedge clk_sys_i);
        #1 ot_warn_i = ferc_reg3_t'(3'b001);
        #1 chk({safe, drv_clr}, 2'b00);
        step();
        chk(warn, 3'b001);
        chk(irq_oe, 1'b0);
        ot_warn_i = ferc_reg3_t'(3'b100);
        #1 chk({safe, drv_clr}, 2'b11);
        step();
        chk({irq_oe, irq_pin}, 2'b10);
        chk(warn, 3'b101);
        ot_warn_i = '0;
        // Wake level and latched edge
        wake_level_i = 1'b1;
        step();
        chk(status_two_o, 8'h03);
        wake_level_i = 1'b0;
        step();
        chk(status_two_o, 8'h02);
        u_ferc_mcu_model.send(CMD_WAKE_CLEAR, 8'h00);
        step();
        chk(status_two_o, 8'h02);
        u_ferc_mcu_model.send(CMD_WAKE_CLEAR, WAKE_CLEAR_DATA);
        step();
        chk(status_two_o, 8'h00);
        wake_level_i = 1'b1;
        step();
        wake_level_i = 1'b0;
        rd(CMD_RD_STATUS_TWO, 8'h02);
        state_i = ST_ACTIVE;
        step();
        state_i = ST_OFF;
        step();
        chk(status_two_o, 8'h00);
        // Mid-run power-on reset restores routing defaults
        reset_n_i = 1'b0;
        step();
        reset_n_i = 1'b1;
        rd(CMD_RD_FAULT_RESET, 8'h0B);
        rd(CMD_RD_THERMAL_IRQ, 8'h00);
        chk({irq_oe, warn}, 4'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
